// File: qdc_map.svh
// Constants of the quad converter serial control block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef QDC_MAP_SVH
`define QDC_MAP_SVH
`define QDC_CHANNELS 4
`define QDC_CODE_W 16
`define QDC_FRAME_BITS 32
`define QDC_CMD_MSB 27
`define QDC_CMD_LSB 24
`define QDC_ADDR_MSB 23
`define QDC_ADDR_LSB 20
`define QDC_DATA_MSB 19
`define QDC_DATA_LSB 4
`define QDC_PD_MSB 9
`define QDC_PD_LSB 8
`define QDC_CHAIN_BIT 1
`define QDC_CLRSEL_MSB 1
`define QDC_CLRSEL_LSB 0
`define QDC_CMD_WR_IN 4'h0
`define QDC_CMD_UPD 4'h1
`define QDC_CMD_WR_UPD_ALL 4'h2
`define QDC_CMD_WR_UPD 4'h3
`define QDC_CMD_POWER 4'h4
`define QDC_CMD_CLR_CODE 4'h5
`define QDC_CMD_SW_RESET 4'h7
`define QDC_CMD_CHAIN 4'h8
`define QDC_ADDR_ALL 4'hf
`define QDC_CODE_ZERO 16'h0000
`define QDC_CODE_MID 16'h8000
`define QDC_CODE_FULL 16'hffff
`define QDC_CLRSEL_RST 2'h0
`define QDC_CLRSEL_MID 2'h1
`define QDC_CLRSEL_FULL 2'h2
`define QDC_CLRSEL_NOP 2'h3
`define QDC_PD_RST 2'h0
`define QDC_CHAIN_RST 1'h0
`define QDC_POR_TIME_NS 50000
`define QDC_CLK_PERIOD_NS 40
`endif

// File: qdc_pkg.sv
// Types shared by the quad converter serial control modules.
// Assumes the constant header is on the include path.
`include "qdc_map.svh"
package qdc_pkg;
	typedef enum logic {QDC_POR_RUN, QDC_POR_DONE} qdc_por_t;
	typedef logic [`QDC_CODE_W-1:0] qdc_code_t;
endpackage : qdc_pkg

// File: qdc_chan_if.sv
// Bundle between the command decoder and the per-channel code registers.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface qdc_chan_if
#(
	parameter int CHANNELS = 4,
	parameter int CODE_W = 16
);
	logic [CHANNELS-1:0] wrInput;
	logic [CHANNELS-1:0] updDac;
	logic loadAll;
	logic clrLoad;
	logic defLoad;
	logic [CODE_W-1:0] dataIn;
	logic [CODE_W-1:0] clrCode;
	logic [CODE_W-1:0] defCode;
	logic [CHANNELS*CODE_W-1:0] dacCodes;
	modport ctrl (output wrInput, updDac, loadAll, clrLoad, defLoad, dataIn,
		clrCode, defCode, input dacCodes);
	modport regs (input wrInput, updDac, loadAll, clrLoad, defLoad, dataIn,
		clrCode, defCode, output dacCodes);
endinterface : qdc_chan_if

// File: qdc_sync2.sv
// Two-stage synchroniser for pins from outside the system clock.
// Assumes each bit is an independent level.
`timescale 1ns/1ps
module qdc_sync2
	import qdc_pkg::*;
#(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
)(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta_q <= INIT;
			q <= INIT;
		end
		else
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : qdc_sync2

// File: qdc_chan_regs.sv
// Input and converter code registers, one pair per channel.
// Assumes the decoder raises at most one load source per cycle of priority.
`timescale 1ns/1ps
module qdc_chan_regs
	import qdc_pkg::*;
#(
	parameter int CHANNELS = 4,
	parameter int CODE_W = 16
)(
	input wire logic clk_sys,
	input wire logic rst_b,
	qdc_chan_if.regs chan
);
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++)
		begin : g_ch
			logic [CODE_W-1:0] inCode_q;
			logic [CODE_W-1:0] dacCode_q;

			always_ff @(posedge clk_sys or negedge rst_b)
			begin
				if (!rst_b)
					inCode_q <= '0;
				else if (chan.defLoad)
					inCode_q <= chan.defCode;
				else if (chan.clrLoad)
					inCode_q <= chan.clrCode;
				else if (chan.wrInput[g])
					inCode_q <= chan.dataIn;
			end

			// Power-down never touches these, so a parked channel keeps
			// and still accepts its code.
			always_ff @(posedge clk_sys or negedge rst_b)
			begin
				if (!rst_b)
					dacCode_q <= '0;
				else if (chan.defLoad)
					dacCode_q <= chan.defCode;
				else if (chan.clrLoad)
					dacCode_q <= chan.clrCode;
				else if (chan.loadAll || chan.updDac[g])
					dacCode_q <= chan.wrInput[g] ? chan.dataIn : inCode_q;
			end

			assign chan.dacCodes[g*CODE_W +: CODE_W] = dacCode_q;
		end
	endgenerate
endmodule : qdc_chan_regs

// File: qdc_top.sv
// Serial control core of a quad voltage-output converter.
// Assumes all pins are asynchronous to clk_sys and the serial clock runs
// at most one eighth of clk_sys.
//
// Operation
// - Command 1000 sets chain mode from bit 1; standalone after reset.
// - In chain mode bits shifted past 32 appear on the serial output.
// - Serial output changes on rising serial clock; far end samples falling.
// - Chained frame ended off a multiple of 32 is discarded unexecuted.
// - No shifting while frame sync is high.
// - Power-up loads defaults; codes zero or midscale per level pin.
// - Command 0111 returns the converter to its power-on code.
// - Load and clear pins are ignored during the power-on sequence.
// - Command 0100 takes power state from bits 9 and 8.
// - Power state goes only to channels selected by bits 3 to 0.
// - Powered-down channel keeps and still updates its converter code.
// - Clear falling edge loads clear code into all registers together.
// - Command 0101 stores clear select from bits 1 and 0.
// - Clear mode ends on the 32nd falling edge of the next write, or on its frame sync rising in chain mode.
// - Clear during a write aborts that write entirely.
// - Load held low: converter registers update on the 32nd falling edge, or on frame sync rising in chain mode.
// - Load low pulse copies input registers; plain writes leave converter registers unchanged.
// - Frame is MSB first: 4 spare, command, address, data.
// - Frame sync rising before 32nd edge changes nothing.
`timescale 1ns/1ps
`include "qdc_map.svh"
module qdc_top
	import qdc_pkg::*;
#(
	parameter int CHANNELS = `QDC_CHANNELS,
	parameter int CODE_W = `QDC_CODE_W,
	parameter int POR_CYCLES = `QDC_POR_TIME_NS / `QDC_CLK_PERIOD_NS
)(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic sclk,
	input wire logic frameSyncN,
	input wire logic din,
	input wire logic load_outputs_n,
	input wire logic async_clear_n,
	input wire logic porLevelSel,
	output logic sdo,
	output logic [CHANNELS*CODE_W-1:0] dacCodes,
	output logic [2*CHANNELS-1:0] pdModes,
	output logic chain_mode_enable,
	output logic [1:0] clearSel,
	output logic clearModeActive,
	output logic porBusy
);
	localparam int FB = `QDC_FRAME_BITS;
	localparam int PW = $clog2(POR_CYCLES + 1);

	generate
		if (CHANNELS != `QDC_CHANNELS || CODE_W != `QDC_CODE_W || POR_CYCLES < 1)
		begin : g_bad_cfg
			$error("qdc_top: unsupported channel count, code width or reset time");
		end
	endgenerate

	logic sclkS;
	logic syncS;
	logic dinS;
	logic loadS;
	logic clrS;
	logic levelS;

	// Every stage starts at the idle-high pin level, so the edge detectors
	// see no false serial clock edge right after reset.
	qdc_sync2 #(.W(6), .INIT(6'h3f)) u_sync (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.d({sclk, frameSyncN, din, load_outputs_n, async_clear_n, porLevelSel}),
		.q({sclkS, syncS, dinS, loadS, clrS, levelS})
	);

	logic sclkD_q;
	logic syncD_q;
	logic loadD_q;
	logic clrD_q;

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sclkD_q <= 1'b1;
			syncD_q <= 1'b1;
			loadD_q <= 1'b1;
			clrD_q <= 1'b1;
		end
		else
		begin
			sclkD_q <= sclkS;
			syncD_q <= syncS;
			loadD_q <= loadS;
			clrD_q <= clrS;
		end
	end

	logic sclkFall;
	logic sclkRise;
	logic syncFall;
	logic syncRise;
	logic loadFall;
	logic clrFall;
	assign sclkFall = sclkD_q & ~sclkS;
	assign sclkRise = ~sclkD_q & sclkS;
	assign syncFall = syncD_q & ~syncS;
	assign syncRise = ~syncD_q & syncS;
	assign loadFall = loadD_q & ~loadS;
	assign clrFall = clrD_q & ~clrS;

	// Power-on sequence.
	qdc_por_t porState_q;
	logic [PW-1:0] porCnt_q;
	logic porDone;
	assign porDone = (porState_q == QDC_POR_DONE);

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			porState_q <= QDC_POR_RUN;
			porCnt_q <= '0;
		end
		else
		begin
			case (porState_q)
				QDC_POR_RUN:
				begin
					porCnt_q <= PW'(porCnt_q + 1'b1);
					if (porCnt_q == PW'(POR_CYCLES - 1))
						porState_q <= QDC_POR_DONE;
				end
				QDC_POR_DONE:
					porCnt_q <= porCnt_q;
				default:
					porState_q <= QDC_POR_RUN;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			porBusy <= 1'b1;
		else
			porBusy <= ~porDone;
	end

	logic clrAccept;
	logic loadAccept;
	assign clrAccept = clrFall & porDone;
	assign loadAccept = loadFall & porDone;

	// Serial frame capture.
	logic [FB-1:0] shift_q;
	logic [4:0] bitCnt_q;
	logic wrap_q;
	logic outBit_q;
	logic abort_q;

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			shift_q <= '0;
			bitCnt_q <= '0;
			wrap_q <= 1'b0;
			outBit_q <= 1'b0;
		end
		else if (syncFall)
		begin
			bitCnt_q <= '0;
			wrap_q <= 1'b0;
		end
		else if (sclkFall && !syncS)
		begin
			shift_q <= {shift_q[FB-2:0], dinS};
			// The bit that now sits on top goes out next, so the next device
			// takes it on the same falling edge that pushes it out of here.
			outBit_q <= shift_q[FB-2];
			bitCnt_q <= 5'(bitCnt_q + 1'b1);
			if (bitCnt_q == 5'h1f)
				wrap_q <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			abort_q <= 1'b0;
		else if (clrAccept && !syncS)
			abort_q <= 1'b1;
		else if (syncFall)
			abort_q <= 1'b0;
	end

	// Serial output moves on rising serial clock edges in chain mode and is held low outside it.
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			sdo <= 1'b0;
		else if (!chain_mode_enable)
			sdo <= 1'b0;
		else if (sclkRise && !syncS)
			sdo <= outBit_q;
	end

	// Standalone frames act on the 32nd falling edge; chained frames wait
	// for frame sync to rise so that every device in the chain latches
	// together, and only a whole multiple of 32 counts.
	logic standExec;
	logic chainExec;
	assign standExec = sclkFall && !syncS && (bitCnt_q == 5'h1f) && !wrap_q
		&& !chain_mode_enable && !abort_q && !clrAccept && porDone;
	assign chainExec = syncRise && chain_mode_enable && wrap_q
		&& (bitCnt_q == 5'h00) && !abort_q && !clrAccept && porDone;

	logic execValid_q;
	logic [FB-1:0] execWord_q;

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			execValid_q <= 1'b0;
			execWord_q <= '0;
		end
		else
		begin
			execValid_q <= standExec | chainExec;
			if (standExec)
				execWord_q <= {shift_q[FB-2:0], dinS};
			else if (chainExec)
				execWord_q <= shift_q;
		end
	end

	logic [3:0] cmd;
	logic [3:0] addr;
	logic [CHANNELS-1:0] addrMask;
	logic swReset;
	assign cmd = execWord_q[`QDC_CMD_MSB:`QDC_CMD_LSB];
	assign addr = execWord_q[`QDC_ADDR_MSB:`QDC_ADDR_LSB];
	assign swReset = execValid_q && (cmd == `QDC_CMD_SW_RESET);

	always_comb
	begin
		addrMask = '0;
		if (addr == `QDC_ADDR_ALL)
			addrMask = '1;
		else if (addr < 4'(CHANNELS))
			addrMask[addr[1:0]] = 1'b1;
	end

	// Control registers.
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			chain_mode_enable <= `QDC_CHAIN_RST;
		else if (swReset)
			chain_mode_enable <= `QDC_CHAIN_RST;
		else if (execValid_q && cmd == `QDC_CMD_CHAIN)
			chain_mode_enable <= execWord_q[`QDC_CHAIN_BIT];
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			clearSel <= `QDC_CLRSEL_RST;
		else if (swReset)
			clearSel <= `QDC_CLRSEL_RST;
		else if (execValid_q && cmd == `QDC_CMD_CLR_CODE)
			clearSel <= execWord_q[`QDC_CLRSEL_MSB:`QDC_CLRSEL_LSB];
	end

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++)
		begin : g_pd
			always_ff @(posedge clk_sys or negedge rst_b)
			begin
				if (!rst_b)
					pdModes[2*g +: 2] <= `QDC_PD_RST;
				else if (swReset)
					pdModes[2*g +: 2] <= `QDC_PD_RST;
				else if (execValid_q && cmd == `QDC_CMD_POWER && execWord_q[g])
					pdModes[2*g +: 2] <= execWord_q[`QDC_PD_MSB:`QDC_PD_LSB];
			end
		end
	endgenerate

	logic clrLoad;
	logic [CODE_W-1:0] clrCode;
	assign clrLoad = clrAccept && (clearSel != `QDC_CLRSEL_NOP);

	always_comb
	begin
		case (clearSel)
			`QDC_CLRSEL_MID: clrCode = `QDC_CODE_MID;
			`QDC_CLRSEL_FULL: clrCode = `QDC_CODE_FULL;
			default: clrCode = `QDC_CODE_ZERO;
		endcase
	end

	// A clear that lands with the ending write wins, so the mode stays set.
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			clearModeActive <= 1'b0;
		else if (clrLoad)
			clearModeActive <= 1'b1;
		else if (execValid_q)
			clearModeActive <= 1'b0;
	end

	// Command decode toward the channel registers.
	qdc_chan_if #(.CHANNELS(CHANNELS), .CODE_W(CODE_W)) chanBus ();

	logic syncLoad;
	assign syncLoad = ~loadS;

	always_comb
	begin
		chanBus.wrInput = '0;
		chanBus.updDac = '0;
		chanBus.loadAll = loadAccept;
		if (execValid_q)
		begin
			case (cmd)
				`QDC_CMD_WR_IN:
				begin
					chanBus.wrInput = addrMask;
					chanBus.updDac = syncLoad ? addrMask : '0;
				end
				`QDC_CMD_UPD:
					chanBus.updDac = addrMask;
				`QDC_CMD_WR_UPD_ALL:
				begin
					chanBus.wrInput = addrMask;
					chanBus.loadAll = 1'b1;
				end
				`QDC_CMD_WR_UPD:
				begin
					chanBus.wrInput = addrMask;
					chanBus.updDac = addrMask;
				end
				default:
					chanBus.wrInput = '0;
			endcase
		end
	end

	// Holding the level-select load through the whole power-on window means
	// the pin is sampled after reset release, never under reset.
	assign chanBus.defLoad = ~porDone | swReset;
	assign chanBus.defCode = levelS ? `QDC_CODE_MID : `QDC_CODE_ZERO;
	assign chanBus.clrLoad = clrLoad;
	assign chanBus.clrCode = clrCode;
	assign chanBus.dataIn = execWord_q[`QDC_DATA_MSB:`QDC_DATA_LSB];

	qdc_chan_regs #(.CHANNELS(CHANNELS), .CODE_W(CODE_W)) u_regs (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.chan(chanBus.regs)
	);

	assign dacCodes = chanBus.dacCodes;

	// Checks.
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	sequence s_exec(logic [3:0] c);
		execValid_q && cmd == c;
	endsequence

	property p_chainSet;
		s_exec(`QDC_CMD_CHAIN) |=>
			chain_mode_enable == $past(execWord_q[`QDC_CHAIN_BIT]);
	endproperty
	a_chainSet: assert property (p_chainSet)
		else $error("chain mode not taken from the command");

	property p_sdoShift;
		chain_mode_enable && sclkRise && !syncS |=> sdo == $past(outBit_q);
	endproperty
	a_sdoShift: assert property (p_sdoShift)
		else $error("serial output not updated on rising clock");

	property p_sdoQuiet;
		!sclkRise && $stable(chain_mode_enable) |=> $stable(sdo);
	endproperty
	a_sdoQuiet: assert property (p_sdoQuiet)
		else $error("serial output moved without a rising clock");

	property p_badChain;
		syncRise && bitCnt_q != 5'h00 |=> !execValid_q;
	endproperty
	a_badChain: assert property (p_badChain)
		else $error("partial chained frame executed");

	property p_holdHigh;
		syncS && !syncFall |=> $stable(shift_q);
	endproperty
	a_holdHigh: assert property (p_holdHigh)
		else $error("shift register moved with frame sync high");

	property p_porIgnore;
		!porDone |=> !clearModeActive && !execValid_q;
	endproperty
	a_porIgnore: assert property (p_porIgnore)
		else $error("activity accepted during power-on");

	property p_swReset;
		s_exec(`QDC_CMD_SW_RESET) |=> !chain_mode_enable
			&& clearSel == `QDC_CLRSEL_RST && pdModes == '0;
	endproperty
	a_swReset: assert property (p_swReset)
		else $error("software reset left settings changed");

	property p_pdKeep;
		s_exec(`QDC_CMD_POWER) && !execWord_q[0] |=> $stable(pdModes[1:0]);
	endproperty
	a_pdKeep: assert property (p_pdKeep)
		else $error("unselected channel power state changed");

	property p_clrExit;
		clearModeActive && execValid_q && !clrLoad |=> !clearModeActive;
	endproperty
	a_clrExit: assert property (p_clrExit)
		else $error("clear mode not left after a write");

	sequence s_abortedFrame;
		clrAccept && !syncS ##1 abort_q [*1];
	endsequence

	property p_abort;
		s_abortedFrame |-> !execValid_q ##1 !execValid_q;
	endproperty
	a_abort: assert property (p_abort)
		else $error("write executed after a clear");

	property p_early;
		syncRise && !wrap_q |=> !execValid_q ##1 !execValid_q;
	endproperty
	a_early: assert property (p_early)
		else $error("interrupted frame executed");
endmodule : qdc_top

// File: qdc_host_model.sv
// Host serial port model that frames commands into the converter core.
// Assumes clk_sys runs eight times faster than the serial clock.
`timescale 1ns/1ps
module qdc_host_model (
	input wire logic clk_sys,
	input wire logic sdo,
	output logic sclk,
	output logic frameSyncN,
	output logic din
);
	logic [63:0] rx;

	initial
	begin
		sclk = 1'b1;
		frameSyncN = 1'b1;
		din = 1'b0;
		rx = '0;
	end

	// The clock stands high between frames, as a gated burst does.
	task automatic send(input logic [63:0] w, input int n);
		@(posedge clk_sys);
		frameSyncN <= 1'b0;
		repeat (4) @(posedge clk_sys);
		for (int i = n - 1; i >= 0; i--)
		begin
			din <= w[i];
			sclk <= 1'b1;
			repeat (4) @(posedge clk_sys);
			sclk <= 1'b0;
			repeat (2) @(posedge clk_sys);
			rx <= {rx[62:0], sdo};
			repeat (2) @(posedge clk_sys);
		end
		sclk <= 1'b1;
		repeat (4) @(posedge clk_sys);
		frameSyncN <= 1'b1;
		// A released data line must not keep looking valid.
		din <= ~din;
		repeat (8) @(posedge clk_sys);
	endtask : send
endmodule : qdc_host_model

// File: tb_top.sv
// Self-checking bench of the quad converter serial control core.
// Assumes the design files and the host model are compiled before it.
`timescale 1ns/1ps
`define CHK(a, b) \
	begin \
		nCompared++; \
		if ((a) !== (b)) \
		begin \
			nMismatch++; \
			$display("wrong value at %0t: %h expected %h", $time, a, b); \
		end \
	end
module tb_top;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic load_outputs_n = 1'b1;
	logic async_clear_n = 1'b1;
	logic porLevelSel = 1'b1;
	wire sclk, frameSyncN, din, sdo;
	wire chain_mode_enable, clearModeActive, porBusy;
	wire [63:0] dacCodes;
	wire [7:0] pdModes;
	wire [1:0] clearSel;
	logic [63:0] mDac, mIn;
	logic [7:0] mPd;
	logic mChain, mClr;
	logic [1:0] mSel;
	logic [75:0] q[$];
	logic [75:0] prev = '0;
	logic [75:0] e;
	logic [31:0] r;
	logic [31:0] seed = 32'he2ae7009;
	int nMismatch = 0;
	int nCompared = 0;
	int cycles = 0;
	wire [75:0] dutSnap = {dacCodes, pdModes, chain_mode_enable, clearSel,
		clearModeActive};

	always #20 clk_sys = ~clk_sys;

	qdc_top #(.POR_CYCLES(8)) i_dut (.clk_sys, .rst_b, .sclk, .frameSyncN,
		.din, .load_outputs_n, .async_clear_n, .porLevelSel, .sdo,
		.dacCodes, .pdModes, .chain_mode_enable, .clearSel,
		.clearModeActive, .porBusy);

	qdc_host_model i_host (.clk_sys, .sdo, .sclk, .frameSyncN, .din);

	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction : rnd

	function automatic logic [75:0] snap();
		return {mDac, mPd, mChain, mSel, mClr};
	endfunction : snap

	task automatic note(input logic [75:0] old);
		if (snap() !== old)
			q.push_back(snap());
	endtask : note

	task automatic give_verdict();
		$display("compared %0d, mismatched %0d", nCompared, nMismatch);
		if (nMismatch == 0 && nCompared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict

	task automatic ldSet(input logic b);
		logic [75:0] old;
		old = snap();
		if (!b && load_outputs_n)
			mDac = mIn;
		note(old);
		@(posedge clk_sys);
		load_outputs_n <= b;
		repeat (6) @(posedge clk_sys);
	endtask : ldSet

	task automatic clrPulse();
		logic [75:0] old;
		old = snap();
		if (mSel != 2'h3)
		begin
			mDac = {4{mSel[1] ? 16'hffff : {mSel[0], 15'h0}}};
			mIn = mDac;
			mClr = 1'b1;
		end
		note(old);
		@(posedge clk_sys);
		async_clear_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		async_clear_n <= 1'b1;
		repeat (6) @(posedge clk_sys);
	endtask : clrPulse

	// Updates the expected state first, then sends the frame.
	task automatic wr(input logic [3:0] c, input logic [3:0] a,
		input logic [19:0] v, input logic [31:0] pre = 32'h0,
		input int n = 32);
		logic [75:0] old;
		logic [3:0] m;
		old = snap();
		m = (a == 4'hf) ? 4'hf : (a < 4) ? 4'h1 << a : 4'h0;
		for (int i = 0; i < 4; i++)
			if (m[i])
			begin
				if (c inside {4'h0, 4'h2, 4'h3})
					mIn[16*i+:16] = v[19:4];
				if (c inside {4'h1, 4'h3} || (c == 4'h0 && !load_outputs_n))
					mDac[16*i+:16] = mIn[16*i+:16];
			end
		for (int i = 0; i < 4; i++)
			if (c == 4'h4 && v[i])
				mPd[2*i+:2] = v[9:8];
		if (c == 4'h2)
			mDac = mIn;
		if (c == 4'h5)
			mSel = v[1:0];
		if (c == 4'h8)
			mChain = v[1];
		if (c == 4'h7)
		begin
			mDac = {4{porLevelSel, 15'h0}};
			mIn = mDac;
			mPd = '0;
			mSel = '0;
			mChain = 1'b0;
		end
		mClr = 1'b0;
		note(old);
		i_host.send({pre, 4'h0, c, a, v}, n);
	endtask : wr

	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			nMismatch++;
			give_verdict();
		end
		if (rst_b && porBusy === 1'b0 && dutSnap !== prev)
		begin
			e = (q.size() > 0) ? q.pop_front() : prev;
			`CHK(dutSnap, e)
		end
		prev <= dutSnap;
	end

	initial
	begin
		mDac = {4{16'h8000}};
		mIn = mDac;
		mPd = '0;
		{mChain, mSel, mClr} = '0;
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk_sys);
		`CHK(porBusy, 1'b1)
		async_clear_n <= 1'b0;
		load_outputs_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		async_clear_n <= 1'b1;
		load_outputs_n <= 1'b1;
		for (int i = 0; i < 50 && porBusy !== 1'b0; i++)
			@(posedge clk_sys);
		`CHK(porBusy, 1'b0)
		repeat (4) @(posedge clk_sys);
		`CHK(dutSnap, snap())
		for (int ld = 1; ld >= 0; ld--)
		begin
			ldSet(ld[0]);
			for (int c = 0; c < 4; c++)
				for (int k = 0; k < 6; k++)
				begin
					r = rnd();
					wr(c[3:0], (k == 4) ? 4'hf : (k == 5) ? 4'h9 : k[3:0],
						{r[15:0], 4'h0});
				end
		end
		ldSet(1'b1);
		`CHK(i_host.rx[31:0], 32'h0)
		for (int m = 3; m >= 0; m--)
		begin
			r = rnd();
			wr(4'h4, 4'h0, {10'h0, m[1:0], 4'h0, r[3:0]});
		end
		wr(4'h3, 4'hf, {r[31:16], 4'h0});
		for (int s = 0; s < 4; s++)
		begin
			wr(4'h5, 4'h0, {18'h0, s[1:0]});
			clrPulse();
			r = rnd();
			wr(4'h0, 4'h2, {r[15:0], 4'h0});
		end
		wr(4'h5, 4'h0, 20'h1);
		r = rnd();
		i_host.send({32'h0, 8'h03, r[23:0]}, 20);
		fork
			i_host.send({32'h0, 8'h03, r[23:0]}, 32);
			begin
				repeat (100) @(posedge clk_sys);
				clrPulse();
			end
		join
		wr(4'h8, 4'h0, 20'h2);
		r = rnd();
		wr(4'h0, 4'h2, {r[31:16], 4'h0}, r, 64);
		`CHK(i_host.rx[31:0], r)
		ldSet(1'b0);
		ldSet(1'b1);
		i_host.send({32'h0, 32'h03f12340}, 40);
		porLevelSel <= 1'b0;
		@(posedge clk_sys);
		wr(4'h7, 4'h0, 20'h0);
		repeat (20) @(posedge clk_sys);
		`CHK(q.size(), 0)
		`CHK(dutSnap, snap())
		give_verdict();
	end
endmodule : tb_top
